// *** twi_master.sv ***
// Two-wire bus master issuing register writes, reads and rereads
`timescale 1ns/10ps
module twi_master (
  // Clock and reset
  input  wire logic          i_mclk,
  input  wire logic          i_nrst,
  // Link
  twi_if.master              bus,
  // Command request
  input  wire logic          i_req,
  input  wire twi_pkg::cmd_t i_cmd,
  input  wire logic          i_fast,
  input  wire logic [6:0]    i_dev,
  input  wire logic [7:0]    i_reg,
  input  wire logic [7:0]    i_wdata,
  // Answer
  output logic               o_busy,
  output logic               o_done,
  output logic               o_nack,
  output logic [7:0]         o_rdata
);

  typedef enum {M_IDLE, M_START, M_BIT, M_STOP} mst_t;

  logic [1:0]  sda_sync_q;
  mst_t        st_q;
  logic [1:0]  ph_q;
  logic [15:0] tmr_q;
  logic [8:0]  sh_q;
  logic [3:0]  bit_q;
  logic [1:0]  byte_q;
  logic [1:0]  nbytes_q;
  logic [7:0]  b0_q;
  logic [7:0]  b1_q;
  logic [7:0]  b2_q;
  logic [7:0]  b3_q;
  logic        rdb_q;
  logic        rd_q;
  logic        fast_q;
  logic        scl_q;
  logic        sda_q;
  logic        busy_q;
  logic        done_q;
  logic        nack_q;
  logic [7:0]  rdata_q;

  wire [15:0] qtr  = fast_q ? 16'(twi_pkg::FAST_QTR) : 16'(twi_pkg::STD_QTR);
  wire        tick = tmr_q == 16'h0;
  wire        sda_s = sda_sync_q[1];
  wire        last_b = byte_q == nbytes_q;

  // ************************************************************
  // Master sequencer: four quarter phases per bit
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sda_sync_q <= 2'h3;
      st_q <= M_IDLE;
      ph_q <= 2'h0;
      tmr_q <= 16'h0;
      sh_q <= 9'h1ff;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      nbytes_q <= 2'h0;
      {b0_q, b1_q, b2_q, b3_q} <= 32'h0;
      rdb_q <= 1'b0;
      rd_q <= 1'b0;
      fast_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      done_q <= 1'b0;
      tmr_q <= tick ? qtr : tmr_q - 16'h1;
      case (st_q)
        M_IDLE:
        begin
          if (i_req)
          begin
            fast_q <= i_fast;
            busy_q <= 1'b1;
            nack_q <= 1'b0;
            byte_q <= 2'h0;
            ph_q   <= 2'h0;
            st_q   <= M_START;
            // Byte lists per command
            b0_q <= {i_dev, 1'b0};
            b1_q <= i_reg;
            b2_q <= (i_cmd == twi_pkg::CMD_WRITE) ? i_wdata : {i_dev, 1'b1};
            b3_q <= 8'hff;
            rdb_q <= i_cmd != twi_pkg::CMD_WRITE;
            if (i_cmd == twi_pkg::CMD_REREAD)
            begin
              b0_q <= {i_dev, 1'b1};
              nbytes_q <= 2'h1;
            end
            else
            begin
              nbytes_q <= (i_cmd == twi_pkg::CMD_READ) ? 2'h3 : 2'h2;
            end
            rd_q <= i_cmd == twi_pkg::CMD_REREAD;
          end
        end
        M_START:
        begin
          // Data high, clock high, then data low while clock high
          if (tick)
          begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: sda_q <= 1'b1;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b0;
              default:
              begin
                scl_q <= 1'b0;
                st_q  <= M_BIT;
                bit_q <= 4'h0;
                // After a repeated start the read-direction address goes out
                sh_q  <= {(byte_q == 2'h2) ? b2_q : b0_q, 1'b1};
              end
            endcase
          end
        end
        M_BIT:
        begin
          if (tick)
          begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: sda_q <= sh_q[8];
              2'h1: scl_q <= 1'b1;
              2'h2:
              begin
                sh_q <= {sh_q[7:0], sda_s};
                if (bit_q == 4'h8 && sda_s && !(rd_q && last_b))
                begin
                  nack_q <= 1'b1;
                end
              end
              default:
              begin
                scl_q <= 1'b0;
                bit_q <= bit_q + 4'h1;
                if (bit_q == 4'h8)
                begin
                  bit_q <= 4'h0;
                  if (last_b || nack_q)
                  begin
                    st_q <= M_STOP;
                  end
                  else if (rdb_q && !rd_q && byte_q == 2'h1)
                  begin
                    // Pointer set; repeated start for the read
                    rd_q   <= 1'b1;
                    byte_q <= 2'h2;
                    st_q   <= M_START;
                  end
                  else
                  begin
                    byte_q <= byte_q + 2'h1;
                    // A read byte loads all ones so the line is left to the slave
                    sh_q <= rd_q ? 9'h1ff : {(byte_q == 2'h0) ? b1_q : b2_q, 1'b1};
                  end
                end
                else if (bit_q == 4'h7)
                begin
                  // Ack slot: release when sending, acknowledge read data
                  sh_q <= {(rd_q && last_b) ? 1'b0 : 1'b1, 8'hff};
                  // Eight shifts of the all-ones load leave the read byte in the low bits
                  if (rd_q && last_b)
                  begin
                    rdata_q <= sh_q[7:0];
                  end
                end
              end
            endcase
          end
        end
        M_STOP:
        begin
          // Data low, clock high, then data released high
          if (tick)
          begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: sda_q <= 1'b0;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b1;
              default:
              begin
                st_q <= M_IDLE;
                busy_q <= 1'b0;
                done_q <= 1'b1;
              end
            endcase
          end
        end
        default:
        begin
          st_q <= M_IDLE;
        end
      endcase
    end
  end

  // Open drain: drive only lows
  assign bus.scl_o    = 1'b0;
  assign bus.scl_oe   = !scl_q;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = !sda_q;
  assign o_busy       = busy_q;
  assign o_done       = done_q;
  assign o_nack       = nack_q;
  assign o_rdata      = rdata_q;

endmodule : twi_master

// *** twi_pkg.sv ***
// Package with constants shared by the two-wire slave port and its master
// Operation
// - Slave only; address 1010 plus select pins
// - Works at standard and fast rates
// - Data changes only while clock low
// - Start/stop: data edge while clock high
// - Write: start, address, direction zero
// - Device acknowledges every write byte
// - Master sends eight-bit register address next
// - Device stores data byte into selected register
// - After last acknowledge: stop or repeated start
// - Pointer kept until reset or overwrite
// - Read: set pointer, repeated start, direction one
// - Device shifts register out; master acknowledges
// - Reread without new register address allowed
// - Device never drives clock; data only when answering
// - Repeated start: data high, clock high, data low
package twi_pkg;

  localparam logic [3:0] ADDR_PREFIX  = 4'ha;
  localparam int         CLK_MHZ      = 125;
  localparam int         STD_KHZ      = 64;
  localparam int         FAST_KHZ     = 400;
  // Quarter-period of the serial clock in system clock cycles
  localparam int         STD_QTR      = (CLK_MHZ * 1000) / (STD_KHZ * 4);
  localparam int         FAST_QTR     = (CLK_MHZ * 1000) / (FAST_KHZ * 4);
  localparam int         REG_COUNT    = 256;
  localparam logic [7:0] PTR_RESET    = 8'h00;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [2:0] BIT_LAST     = 3'h7;

  typedef enum logic [1:0] {
    CMD_WRITE,
    CMD_READ,
    CMD_REREAD
  } cmd_t;

endpackage : twi_pkg

// *** twi_if.sv ***
// Interface joining the two ends of the two-wire link
`timescale 1ns/10ps
interface twi_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  // Open-drain wired-and with pull-up
  wire  scl = !(scl_oe && !scl_o);
  wire  sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

  modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
                  input scl, input sda);
  modport slave  (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : twi_if

// *** twi_slave.sv ***
// Two-wire slave port holding the device's 8-bit control registers
`timescale 1ns/10ps
module twi_slave (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  // Link
  twi_if.slave            bus,
  // Select pins and register view
  input  wire logic [2:0] i_addr_sel,
  output logic      [7:0] o_ptr,
  output logic      [7:0] o_wr_data,
  output logic            o_wr_stb
);

  typedef enum {S_IDLE, S_ADDR, S_ACK, S_RXB, S_TXB, S_TXACK, S_SKIP} st_t;

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [2:0] sel_meta_q;
  logic [2:0] sel_q;
  logic       scl_q;
  logic       sda_q;
  st_t        st_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic       rd_q;
  logic       reg_phase_q;
  logic [7:0] ptr_q;
  logic [7:0] regs_q [twi_pkg::REG_COUNT];
  logic       drv_q;
  logic       out_q;
  logic [7:0] wr_data_q;
  logic       wr_stb_q;

  // ************************************************************
  // Pin sampling and event decode
  // ************************************************************
  wire scl_s   = scl_sync_q[1];
  wire sda_s   = sda_sync_q[1];
  wire rise    = scl_s && !scl_q;
  wire fall    = !scl_s && scl_q;
  wire start_c = scl_s && scl_q && sda_q && !sda_s;
  wire stop_c  = scl_s && scl_q && !sda_q && sda_s;
  wire [7:0] rx_byte = {sh_q[6:0], sda_s};
  // Select pins are board straps but still pass two stages before use
  wire addr_hit = rx_byte[7:1] == {twi_pkg::ADDR_PREFIX, sel_q};

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      sel_meta_q <= 3'h0;
      sel_q      <= 3'h0;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      sel_meta_q <= i_addr_sel;
      sel_q      <= sel_meta_q;
      scl_q      <= scl_s;
      sda_q      <= sda_s;
    end
  end

  // ************************************************************
  // Protocol engine; samples on rise, drives on fall
  // ************************************************************
  // Rates come from the master alone, so any speed up to fast works
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_q        <= S_IDLE;
      cnt_q       <= 3'h0;
      sh_q        <= 8'h00;
      rd_q        <= 1'b0;
      reg_phase_q <= 1'b0;
      ptr_q       <= twi_pkg::PTR_RESET;
      drv_q       <= 1'b0;
      out_q       <= 1'b1;
      wr_data_q   <= 8'h00;
      wr_stb_q    <= 1'b0;
    end
    else
    begin
      wr_stb_q <= 1'b0;
      if (start_c)
      begin
        st_q  <= S_ADDR;
        cnt_q <= 3'h0;
        drv_q <= 1'b0;
      end
      else if (stop_c)
      begin
        st_q  <= S_IDLE;
        drv_q <= 1'b0;
      end
      else
      begin
        case (st_q)
          S_ADDR:
          begin
            if (rise)
            begin
              sh_q  <= rx_byte;
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == twi_pkg::BIT_LAST)
              begin
                rd_q        <= sda_s;
                reg_phase_q <= !sda_s;
                st_q        <= addr_hit ? S_ACK : S_SKIP;
              end
            end
          end
          S_ACK:
          begin
            // Acknowledge driven on the low phase; after the pulse released on writes, data MSB driven on reads
            if (fall && !drv_q)
            begin
              drv_q <= 1'b1;
              out_q <= 1'b0;
            end
            else if (fall && drv_q)
            begin
              cnt_q <= 3'h0;
              if (rd_q)
              begin
                st_q  <= S_TXB;
                sh_q  <= regs_q[ptr_q];
                out_q <= regs_q[ptr_q][7];
              end
              else
              begin
                drv_q <= 1'b0;
                st_q  <= S_RXB;
              end
            end
          end
          S_RXB:
          begin
            if (rise)
            begin
              sh_q  <= rx_byte;
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == twi_pkg::BIT_LAST)
              begin
                st_q <= S_ACK;
                if (reg_phase_q)
                begin
                  ptr_q       <= rx_byte;
                  reg_phase_q <= 1'b0;
                end
                else
                begin
                  wr_data_q <= rx_byte;
                  wr_stb_q  <= 1'b1;
                end
              end
            end
          end
          S_TXB:
          begin
            if (fall)
            begin
              cnt_q <= cnt_q + 3'h1;
              sh_q  <= {sh_q[6:0], 1'b0};
              out_q <= sh_q[6];
              if (cnt_q == twi_pkg::BIT_LAST)
              begin
                drv_q <= 1'b0;
                st_q  <= S_TXACK;
              end
            end
          end
          S_TXACK:
          begin
            // Master acknowledge taken; single-byte reads, so wait for stop
            if (rise)
            begin
              st_q <= S_SKIP;
            end
          end
          default:
          begin
            st_q <= st_q;
          end
        endcase
      end
    end
  end

  // Register array; stored one cycle after the data byte
  always_ff @(posedge i_mclk)
  begin
    if (wr_stb_q)
    begin
      regs_q[ptr_q] <= wr_data_q;
    end
  end

  // Clock line never driven: no clock output exists here
  assign bus.sda_s_o  = out_q;
  assign bus.sda_s_oe = drv_q;
  assign o_ptr        = ptr_q;
  assign o_wr_data    = wr_data_q;
  assign o_wr_stb     = wr_stb_q;

endmodule : twi_slave

// *** twi_link_sva.sv ***
// Checker watching the two-wire link between master and slave
`timescale 1ns/10ps
module twi_link_sva (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Link
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  // ****************
  // Bit tracking
  // ****************
  logic        scl_q;
  logic        sda_q;
  logic        first_q;
  logic        rd_q;
  logic        dat_q;
  logic [3:0]  cnt_q;
  logic [10:0] lo_q;
  wire         s_low = sda_s_oe && !sda_s_o;
  wire         st    = scl && scl_q && sda_q && !sda;
  wire         sp    = scl && scl_q && !sda_q && sda;
  wire         rise  = scl && !scl_q;
  wire         ack   = cnt_q == 4'h8;
  // Low time saturates far above any legal value so it never wraps
  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
      lo_q <= 11'h0;
    else
      lo_q <= scl ? 11'h0 : lo_q + {10'h0, lo_q != 11'h7ff};
  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
    begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      cnt_q   <= 4'h0;
      first_q <= 1'b0;
      rd_q    <= 1'b0;
      dat_q   <= 1'b0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (st || sp)
      begin
        cnt_q   <= 4'h0;
        first_q <= st;
        dat_q   <= 1'b0;
      end
      else if (rise)
      begin
        cnt_q <= ack ? 4'h0 : cnt_q + 4'h1;
        if (cnt_q == 4'h7 && first_q)
          rd_q <= sda;
        if (ack)
          first_q <= 1'b0;
        if (ack)
          dat_q <= first_q && rd_q && !sda;
      end
    end
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  chk_slave_scl_low: assert property ($changed(s_low) |-> !scl && !scl_q)
    else $error("slave data moved while clock high");
  chk_ack_slot: assert property (rise && s_low |-> ack || dat_q)
    else $error("slave drove data outside its slots");
  chk_start_free: assert property (st |-> !s_low)
    else $error("slave held data at start");
  chk_stop_free: assert property (sp |-> !sda_s_oe)
    else $error("slave enabled at stop");
  chk_rd_ack_free: assert property (rise && ack && dat_q |-> !s_low)
    else $error("slave drove the master acknowledge");
  chk_ack_hold: assert property (rise && s_low |-> s_low [*8])
    else $error("slave low level not held");
  chk_scl_low_min: assert property (rise |-> lo_q >= twi_pkg::FAST_QTR - 2)
    else $error("clock low phase too short");
  chk_scl_low_max: assert property (rise |-> lo_q <= 3 * twi_pkg::STD_QTR)
    else $error("clock low phase too long");
endmodule : twi_link_sva

// *** i2c_slave_register_port_test.sv ***
// Self-checking bench joining master and slave ends of the link
`timescale 1ns/10ps
module i2c_slave_register_port_test;
  // ****************
  // Harness
  // ****************
  logic          i_mclk, i_nrst, req, fast, busy, done, nack, stb;
  twi_pkg::cmd_t cmd;
  logic [6:0]    dev;
  logic [2:0]    sel;
  logic [7:0]    rg, wd, rdata, ptr, wdat, ab, sh;
  int            n_fail, cmp_count, cyc, nstb, nb;
  twi_if tw ();
  twi_slave twi_slave_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .bus(tw.slave),
    .i_addr_sel(sel), .o_ptr(ptr), .o_wr_data(wdat), .o_wr_stb(stb));
  twi_master twi_master_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .bus(tw.master),
    .i_req(req), .i_cmd(cmd), .i_fast(fast), .i_dev(dev), .i_reg(rg), .i_wdata(wd),
    .o_busy(busy), .o_done(done), .o_nack(nack), .o_rdata(rdata));
  twi_link_sva twi_link_sva_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .scl(tw.scl),
    .sda(tw.sda), .sda_s_o(tw.sda_s_o), .sda_s_oe(tw.sda_s_oe));
  initial
  begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  // Ceiling a little above the whole sequence, about 89,500 cycles
  always @(posedge i_mclk)
  begin
    cyc++;
    if (stb === 1'b1)
      nstb++;
    if (cyc == 96000)
    begin
      n_fail++;
      stop_test();
    end
  end
  // Address byte as seen on the wire after the latest start
  always @(negedge tw.sda)
    if (tw.scl === 1'b1)
      nb = 0;
  always @(posedge tw.scl)
  begin
    sh = {sh[6:0], tw.sda};
    nb++;
    if (nb == 8)
      ab = sh;
  end
  // ****************
  // Tasks
  // ****************
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task go(input twi_pkg::cmd_t c, input logic f, input logic [6:0] d,
          input logic [7:0] r, w);
    @(posedge i_mclk);
    cmd  <= c;
    fast <= f;
    dev  <= d;
    rg   <= r;
    wd   <= w;
    req  <= 1'b1;
    while (done !== 1'b1)
    begin
      @(posedge i_mclk);
      if (busy === 1'b1)
        req <= 1'b0;
    end
    chk({6'h0, tw.scl, tw.sda}, 8'h03);
  endtask : go
  task wr(input logic f, input logic [6:0] d, input logic [7:0] r, w,
          input logic ok, input logic [7:0] ep);
    int s;
    s = nstb;
    go(twi_pkg::CMD_WRITE, f, d, r, w);
    chk({7'h0, nack}, {7'h0, !ok});
    chk(8'(nstb - s), {7'h0, ok});
    if (ok)
      chk(wdat, w);
    chk(ptr, ep);
    chk(ab, {d, 1'b0});
  endtask : wr
  task rd(input twi_pkg::cmd_t c, input logic f, input logic [6:0] d,
          input logic [7:0] r, e, ep);
    go(c, f, d, r, 8'h00);
    chk({7'h0, nack}, 8'h00);
    chk(rdata, e);
    chk(ptr, ep);
    chk(ab, {d, 1'b1});
  endtask : rd
  // ****************
  // Sequence
  // ****************
  initial
  begin
    i_nrst    = 1'b0;
    req       = 1'b0;
    cmd       = twi_pkg::CMD_WRITE;
    fast      = 1'b1;
    dev       = 7'h00;
    rg        = 8'h00;
    wd        = 8'h00;
    sel       = 3'h3;
    n_fail    = 0;
    cmp_count = 0;
    cyc       = 0;
    nstb      = 0;
    nb        = 99;
    ab        = 8'h00;
    sh        = 8'h00;
    repeat (3) @(posedge i_mclk);
    i_nrst <= 1'b1;
    chk(ptr, twi_pkg::PTR_RESET);
    wr(1'b1, 7'h53, 8'h6d, 8'h92, 1'b1, 8'h6d);
    rd(twi_pkg::CMD_READ, 1'b1, 7'h53, 8'h6d, 8'h92, 8'h6d);
    rd(twi_pkg::CMD_REREAD, 1'b0, 7'h53, 8'h00, 8'h92, 8'h6d);
    wr(1'b1, 7'h53, 8'hff, 8'ha5, 1'b1, 8'hff);
    wr(1'b1, 7'h54, 8'h6d, 8'h11, 1'b0, 8'hff);
    wr(1'b1, 7'h13, 8'h6d, 8'h22, 1'b0, 8'hff);
    rd(twi_pkg::CMD_REREAD, 1'b1, 7'h53, 8'h00, 8'ha5, 8'hff);
    // Select pins move between transfers only
    sel <= 3'h5;
    rd(twi_pkg::CMD_REREAD, 1'b1, 7'h55, 8'h00, 8'ha5, 8'hff);
    stop_test();
  end
endmodule : i2c_slave_register_port_test
